// [src/egress_queue_scheduler.sv]
// egress frame scheduler: strict priority plus deficit weighted rotation over
// eight unicast and eight multicast queues, descriptors buffered toward transmit
// assumes: queues and transmit path run on hclk; a queue updates req/len in the
// cycle after its grant pulse; AHB-Lite single word transfers
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "sched_map.svh"

// descriptor buffer between the scheduler and the transmit path
module sched_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // occupancy
  output logic [$clog2(DEPTH):0]        level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  // handshakes
  assign in_ready  = (count_reg != DEPTH[PW:0]);
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];
  assign level     = count_reg;

  // storage
  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end
endmodule

module egress_queue_scheduler
  import sched_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic                                 hclk,
  input  wire logic                                 hresetn,
  // AHB-Lite register slave
  input  wire logic                                 hsel,
  input  wire logic [31:0]                          haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [31:0]                          hwdata,
  input  wire logic                                 hready,
  output logic                                      hreadyout,
  output logic                                      hresp,
  output logic [31:0]                               hrdata,
  // unicast queues, one per class
  input  wire logic [`SCHED_NCLASS-1:0]                   uc_req,
  input  wire logic [`SCHED_NCLASS-1:0][`SCHED_LEN_W-1:0] uc_len,
  output logic [`SCHED_NCLASS-1:0]                        uc_grant,
  // multicast expansion queues, one per class
  input  wire logic [`SCHED_NCLASS-1:0]                   mc_req,
  input  wire logic [`SCHED_NCLASS-1:0][`SCHED_LEN_W-1:0] mc_len,
  output logic [`SCHED_NCLASS-1:0]                        mc_grant,
  // transmit path
  output logic                                      tx_valid,
  input  wire logic                                 tx_ready,
  output desc_t                                     tx_desc
);
  localparam int NC = `SCHED_NCLASS;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  typedef logic signed [`SCHED_DEF_W-1:0] deficit_t;

  sched_state_t                  state_reg;
  logic [31:0]                   ctrl_reg;
  logic [`SCHED_WEIGHT_W-1:0]    weight_reg [NC];
  deficit_t                      deficit_reg [NC];
  logic [NC-1:0]                 rr_reg;
  logic [2:0]                    ptr_reg;
  desc_t                         sel_reg;
  logic [31:0]                   hrdata_reg;
  logic                          wr_pend_reg;
  logic [`SCHED_ADDR_W-1:0]      waddr_reg;

  logic [3:0]                    nstrict;
  logic [NC-1:0]                 cls_strict;
  logic [NC-1:0]                 cls_busy;
  logic [NC-1:0]                 cls_mc;
  logic                          strict_any;
  logic [2:0]                    strict_cls;
  logic                          weighted_any;
  logic                          w_ok;
  logic [2:0]                    ptr_next;
  desc_t                         pick;
  logic                          fifo_in_ready;
  logic [LW-1:0]                 fifo_level;
  logic                          issue_done;
  logic                          addr_ok;
  logic [2:0]                    ridx;
  logic [2:0]                    widx;

  // strict class count, clamped to the number of classes
  always_comb begin
    nstrict = ctrl_reg[`SCHED_NSTRICT_MSB:`SCHED_NSTRICT_LSB];
    if (nstrict > `SCHED_NSTRICT_MAX) begin
      nstrict = `SCHED_NSTRICT_MAX;
    end
  end

  // per class service level and occupancy; multicast shares the unicast class
  for (genvar c = 0; c < NC; c++) begin : g_cls
    assign cls_strict[c] = ({1'b0, 4'(c)} + {1'b0, nstrict}) >= 5'(NC);
    assign cls_busy[c]   = uc_req[c] || mc_req[c];
    assign cls_mc[c]     = (uc_req[c] && mc_req[c]) ? rr_reg[c] : mc_req[c];
  end

  // highest nonempty strict class; later index wins so class 7 is highest
  always_comb begin
    strict_any = 1'b0;
    strict_cls = '0;
    for (int i = 0; i < NC; i++) begin
      if (cls_strict[i] && cls_busy[i]) begin
        strict_any = 1'b1;
        strict_cls = 3'(i);
      end
    end
  end

  // weighted candidates and the visit order
  assign weighted_any = |(cls_busy & ~cls_strict);
  assign w_ok = !cls_strict[ptr_reg] && cls_busy[ptr_reg]
                && (deficit_reg[ptr_reg] > 0);
  assign ptr_next = (ptr_reg == 3'h0) ? 3'(NC - 1) : ptr_reg - 3'h1;

  // decision for this pick cycle; strict always ahead of weighted
  always_comb begin
    pick.tclass = strict_any ? strict_cls : ptr_reg;
    pick.mcast  = cls_mc[pick.tclass];
    pick.len    = pick.mcast ? mc_len[pick.tclass] : uc_len[pick.tclass];
  end

  assign issue_done = (state_reg == ST_ISSUE) && fifo_in_ready;

  // sequencing: one decision per whole frame, never mid frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_OFF;
    end else begin
      unique case (state_reg)
        ST_OFF: begin
          if (ctrl_reg[`SCHED_CTRL_EN_BIT]) begin
            state_reg <= ST_PICK;
          end
        end
        ST_PICK: begin
          if (!ctrl_reg[`SCHED_CTRL_EN_BIT]) begin
            state_reg <= ST_OFF;
          end else if (strict_any || w_ok) begin
            state_reg <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (fifo_in_ready) begin
            state_reg <= ST_PICK;
          end
        end
      endcase
    end
  end

  // chosen descriptor held until the buffer takes it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_reg <= '0;
    end else if (state_reg == ST_PICK && (strict_any || w_ok)) begin
      sel_reg <= pick;
    end
  end

  // rotation between the unicast and multicast queue of a class
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rr_reg <= '0;
    end else if (issue_done) begin
      rr_reg[sel_reg.tclass] <= !sel_reg.mcast;
    end
  end

  // weighted visit pointer, moves only when the current class is finished
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_reg <= `SCHED_PTR_START;
    end else if (state_reg == ST_PICK && !strict_any && !w_ok && weighted_any) begin
      ptr_reg <= ptr_next;
    end
  end

  // deficit per class: credit on arrival, charge per frame, keep the excess
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NC; i++) begin
        deficit_reg[i] <= '0;
      end
    end else if (state_reg == ST_PICK && ctrl_reg[`SCHED_CTRL_EN_BIT] && !strict_any) begin
      if (w_ok) begin
        deficit_reg[ptr_reg] <= deficit_reg[ptr_reg]
                                - deficit_t'({1'b0, pick.len});
      end else if (weighted_any) begin
        if (!cls_strict[ptr_next] && cls_busy[ptr_next]) begin
          deficit_reg[ptr_next] <= deficit_reg[ptr_next]
                                   + deficit_t'({1'b0, weight_reg[ptr_next]});
        end else if (deficit_reg[ptr_next] > 0) begin
          deficit_reg[ptr_next] <= '0; // an idle class banks no credit
        end
      end
    end
  end

  // grant pulses in the cycle the descriptor enters the buffer
  always_comb begin
    uc_grant = '0;
    mc_grant = '0;
    if (issue_done) begin
      uc_grant[sel_reg.tclass] = !sel_reg.mcast;
      mc_grant[sel_reg.tclass] = sel_reg.mcast;
    end
  end

  // descriptor buffer; a full buffer stalls the issue state
  sched_fifo #(
    .WIDTH ($bits(desc_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (state_reg == ST_ISSUE),
    .in_ready  (fifo_in_ready),
    .in_data   (sel_reg),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_desc),
    .level     (fifo_level)
  );

  // AHB-Lite address phase decode
  assign addr_ok   = hsel && hready && htrans[1];
  assign ridx      = haddr[4:2];
  assign widx      = waddr_reg[4:2];
  assign hreadyout = 1'b1; // zero wait state
  assign hresp     = 1'b0; // always OKAY
  assign hrdata    = hrdata_reg;

  // write request captured in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      waddr_reg   <= '0;
    end else if (hready) begin
      wr_pend_reg <= addr_ok && hwrite;
      waddr_reg   <= haddr[`SCHED_ADDR_W-1:0];
    end
  end

  // control and weight registers, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `SCHED_CTRL_RESET;
      for (int i = 0; i < NC; i++) begin
        weight_reg[i] <= `SCHED_WEIGHT_RESET;
      end
    end else if (wr_pend_reg) begin
      if (waddr_reg == `SCHED_CTRL_OFF) begin
        ctrl_reg <= hwdata;
      end else if ((waddr_reg & `SCHED_BANK_MASK) == `SCHED_WEIGHT_BASE) begin
        weight_reg[widx] <= hwdata[`SCHED_WEIGHT_W-1:0];
      end
    end
  end

  // read data loaded in the address phase; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (addr_ok && !hwrite) begin
      hrdata_reg <= '0;
      if (haddr[`SCHED_ADDR_W-1:0] == `SCHED_CTRL_OFF) begin
        hrdata_reg <= ctrl_reg;
      end else if (haddr[`SCHED_ADDR_W-1:0] == `SCHED_STATUS_OFF) begin
        hrdata_reg[`SCHED_ST_STATE_LSB +: 3] <= state_reg;
        hrdata_reg[`SCHED_ST_LAST_LSB +: 4]  <= {sel_reg.mcast, sel_reg.tclass};
        hrdata_reg[`SCHED_ST_PTR_LSB +: 3]   <= ptr_reg;
        hrdata_reg[`SCHED_ST_FIFO_LSB +: LW] <= fifo_level;
      end else if ((haddr[`SCHED_ADDR_W-1:0] & `SCHED_BANK_MASK) == `SCHED_WEIGHT_BASE) begin
        hrdata_reg[`SCHED_WEIGHT_W-1:0] <= weight_reg[ridx];
      end else if ((haddr[`SCHED_ADDR_W-1:0] & `SCHED_BANK_MASK) == `SCHED_DEFICIT_BASE) begin
        hrdata_reg <= 32'(deficit_reg[ridx]); // sign extended
      end
    end
  end
endmodule

// [include/sched_map.svh]
// egress scheduler register map, field positions, reset values and sizes
// assumes: included by bare name by the scheduler package and the scheduler itself
`ifndef SCHED_MAP_SVH
`define SCHED_MAP_SVH

// sizes
`define SCHED_NCLASS      8
`define SCHED_LEN_W       14
`define SCHED_WEIGHT_W    16
`define SCHED_DEF_W       18
`define SCHED_ADDR_W      8

// register byte offsets
`define SCHED_CTRL_OFF    8'h00
`define SCHED_STATUS_OFF  8'h04
`define SCHED_WEIGHT_BASE 8'h20
`define SCHED_DEFICIT_BASE 8'h40
`define SCHED_BANK_MASK   8'hE0

// control fields
`define SCHED_CTRL_EN_BIT  0
`define SCHED_NSTRICT_LSB  4
`define SCHED_NSTRICT_MSB  7
`define SCHED_NSTRICT_MAX  4'h8

// status fields
`define SCHED_ST_STATE_LSB 0
`define SCHED_ST_LAST_LSB  4
`define SCHED_ST_PTR_LSB   8
`define SCHED_ST_FIFO_LSB  16

// reset values
`define SCHED_CTRL_RESET   32'h0000_0001
`define SCHED_WEIGHT_RESET 16'h0600
`define SCHED_PTR_START    3'h7

`endif

// [include/sched_pkg.sv]
// types shared by the egress scheduler and its bench
// assumes: sched_map.svh is on the include path
`include "sched_map.svh"

package sched_pkg;

  // one scheduling decision: which queue sends its head frame, and its length
  typedef struct packed {
    logic                     mcast;
    logic [2:0]               tclass;
    logic [`SCHED_LEN_W-1:0]  len;
  } desc_t;

  // scheduler sequencing
  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_PICK  = 3'b010,
    ST_ISSUE = 3'b100
  } sched_state_t;

endpackage

// [verification/egress_queue_scheduler_sva.sv]
// port checker for the egress frame scheduler
// assumes: bound onto egress_queue_scheduler, sched_pkg compiled first
`timescale 1ns/1ps

module egress_queue_scheduler_sva
  import sched_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic                   hclk,
  input wire logic                   hresetn,
  // bus answer
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  // queues
  input wire logic [7:0]             uc_req,
  input wire logic [7:0][13:0]       uc_len,
  input wire logic [7:0]             uc_grant,
  input wire logic [7:0]             mc_req,
  input wire logic [7:0][13:0]       mc_len,
  input wire logic [7:0]             mc_grant,
  // transmit path
  input wire logic                   tx_valid,
  input wire logic                   tx_ready,
  input wire desc_t                  tx_desc
);
  logic       any_g;
  logic       gm;
  logic [2:0] gcls;
  logic [13:0] glen;

  // decode the granted queue and its head length
  always_comb begin
    gcls = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (uc_grant[i] || mc_grant[i]) begin
        gcls = 3'(i);
      end
    end
    gm    = |mc_grant;
    any_g = |{uc_grant, mc_grant};
    glen  = gm ? mc_len[gcls] : uc_len[gcls];
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_ONE_GRANT: assert property ($onehot0({uc_grant, mc_grant}))
    else $error("more than one queue granted");
  AST_GRANT_BUSY: assert property (((uc_grant & ~uc_req) | (mc_grant & ~mc_req)) == 8'h00)
    else $error("grant to an empty queue");
  AST_GRANT_GAP: assert property (any_g |=> !any_g)
    else $error("grants on adjacent cycles");
  AST_GRANT_PUSH: assert property (any_g |=> tx_valid)
    else $error("grant left no descriptor");
  AST_DESC: assert property ((any_g && !tx_valid) |=>
      tx_desc == {$past(gm), $past(gcls), $past(glen)})
    else $error("descriptor does not match granted queue");
  AST_HOLD: assert property ((tx_valid && !tx_ready) |=> tx_valid && $stable(tx_desc))
    else $error("descriptor changed while stalled");
  AST_READY: assert property (hreadyout)
    else $error("bus wait state inserted");
  AST_OKAY: assert property (!hresp)
    else $error("bus error response");
endmodule

bind egress_queue_scheduler egress_queue_scheduler_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .uc_req(uc_req), .uc_len(uc_len), .uc_grant(uc_grant), .mc_req(mc_req),
  .mc_len(mc_len), .mc_grant(mc_grant), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_desc(tx_desc)
);

// [verification/queue_peer.sv]
// frame queues and transmit sink facing the scheduler
// assumes: bench raises added[] and stall by non-blocking assignment at clock edges
`timescale 1ns/1ps

module queue_peer (
  // clock
  input wire logic             hclk,
  // queues, 0..7 unicast, 8..15 multicast
  output logic [7:0]           uc_req,
  output logic [7:0][13:0]     uc_len,
  input wire logic [7:0]       uc_grant,
  output logic [7:0]           mc_req,
  output logic [7:0][13:0]     mc_len,
  input wire logic [7:0]       mc_grant,
  // transmit sink
  output logic                 tx_ready = 1'b0
);
  int unsigned added [16] = '{default: 0};
  int unsigned taken [16] = '{default: 0};
  logic [13:0] len_q [16];
  int unsigned flen  = 0;
  bit          stall = 0;

  function automatic logic [13:0] new_len();
    return (flen != 0) ? 14'(flen) : 14'(64 + $urandom_range(1454));
  endfunction

  initial for (int q = 0; q < 16; q++) len_q[q] = new_len();

  // dequeue the head frame at its grant edge, sink takes at random
  always @(posedge hclk) begin
    tx_ready <= !stall && ($urandom_range(3) != 0);
    for (int q = 0; q < 16; q++) begin
      if ((q < 8) ? uc_grant[q] : mc_grant[q-8]) begin
        taken[q] <= taken[q] + 1;
        len_q[q] <= new_len();
      end
    end
  end

  // a queue requests while it holds frames
  always_comb begin
    for (int q = 0; q < 8; q++) begin
      uc_req[q] = added[q] != taken[q];
      mc_req[q] = added[q+8] != taken[q+8];
      uc_len[q] = len_q[q];
      mc_len[q] = len_q[q+8];
    end
  end
endmodule

// [verification/tb_top.sv]
// self-checking bench for the egress frame scheduler
// assumes: one AHB-Lite master, queue_peer as the far side
`timescale 1ns/1ps

module tb_top;
  import sched_pkg::*;
  logic            hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0]     haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]      htrans = 0;
  logic [2:0]      hsize = 0;
  logic            hreadyout, hresp, tx_valid, tx_ready;
  logic [7:0]      uc_req, uc_grant, mc_req, mc_grant, last_m, last_both = 0;
  logic [7:0][13:0] uc_len, mc_len;
  desc_t           tx_desc;
  desc_t           sb [$];
  int              err_total = 0, comparisons = 0, nstrict = 0, ngrant = 0, prev = -1;
  int              bytes [8];
  bit              order_on = 0;

  always #2.5 hclk = ~hclk;

  egress_queue_scheduler u_egress_queue_scheduler (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .uc_req(uc_req), .uc_len(uc_len), .uc_grant(uc_grant),
    .mc_req(mc_req), .mc_len(mc_len), .mc_grant(mc_grant), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_desc(tx_desc));
  queue_peer u_queue_peer (.hclk(hclk), .uc_req(uc_req), .uc_len(uc_len),
    .uc_grant(uc_grant), .mc_req(mc_req), .mc_len(mc_len), .mc_grant(mc_grant),
    .tx_ready(tx_ready));

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[FAIL] %0t %s count %0d", $time, what, got);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one single-word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // highest busy class among the strict ones, -1 if none
  function automatic int top_strict(input logic [7:0] busy, input int n);
    int r = -1;
    for (int i = 0; i < 8; i++) if (busy[i] && i >= 8 - n) r = i;
    return r;
  endfunction

  // wait until every queue and the buffer are empty; a hang is left to the watchdog
  task automatic settle();
    do @(posedge hclk); while ((|uc_req) || (|mc_req) || tx_valid);
  endtask

  task automatic load(input int q, input int n);
    u_queue_peer.added[q] <= u_queue_peer.added[q] + n;
  endtask

  // scoreboard, priority and rotation checks at each grant
  always @(posedge hclk) begin : mon
    desc_t d;
    if (hresetn) begin
      if (tx_valid && tx_ready) chk_val(32'(tx_desc), 32'(sb.pop_front()), "desc");
      if (|{uc_grant, mc_grant}) begin
        d.mcast = |mc_grant;
        for (int i = 0; i < 8; i++) if (uc_grant[i] | mc_grant[i]) d.tclass = 3'(i);
        d.len = d.mcast ? mc_len[d.tclass] : uc_len[d.tclass];
        sb.push_back(d);
        ngrant++;
        bytes[d.tclass] += int'(d.len);
        if (top_strict(uc_req | mc_req, nstrict) >= 0)
          chk_val(32'(d.tclass), 32'(top_strict(uc_req | mc_req, nstrict)), "strict");
        if (uc_req[d.tclass] && mc_req[d.tclass] && last_both[d.tclass])
          chk_val(32'(d.mcast), 32'(!last_m[d.tclass]), "rotation");
        if (order_on && prev >= 0) chk_val(32'(d.tclass), 32'((prev + 7) % 8), "order");
        prev = d.tclass;
        last_m[d.tclass] = d.mcast;
        last_both[d.tclass] = uc_req[d.tclass] && mc_req[d.tclass];
      end
    end
  end

  initial begin
    void'($urandom(32'h33a2_7c1f));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values and an unmapped place
    ahb(0, 8'h00, 0); chk_val(rd, 32'h0000_0001, "ctrl");
    for (int c = 0; c < 8; c++) begin
      ahb(0, 8'h20 + 8'(4 * c), 0); chk_val(rd, 32'h0000_0600, "weight");
    end
    ahb(0, 8'h80, 0); chk_val(rd, 32'h0000_0000, "unmapped");
    // strict counts 8 down to 1 with random unicast and multicast load
    for (int n = 8; n >= 1; n--) begin
      ahb(1, 8'h00, 32'((n << 4) | 1)); nstrict = n;
      for (int q = 0; q < 16; q++) load(q, $urandom_range(3));
      settle();
    end
    // all weighted: classes 7 and 6 at weights 2:1
    ahb(1, 8'h00, 32'h0000_0001); nstrict = 0;
    ahb(1, 8'h3C, 32'h0000_0400);
    ahb(1, 8'h38, 32'h0000_0200);
    u_queue_peer.flen = 256; ngrant = 0; bytes = '{default: 0};
    load(7, 60); load(6, 60);
    while (ngrant < 60) @(posedge hclk);
    chk_cnt(bytes[7] - 2 * bytes[6], -3000, 3000, "share");
    settle();
    // one frame per class: visited from high to low, wrapping
    ahb(1, 8'h3C, 32'h0000_0600); ahb(1, 8'h38, 32'h0000_0600);
    order_on = 1; prev = -1;
    for (int q = 0; q < 8; q++) load(q, 1);
    settle(); order_on = 0;
    // stalled transmit: buffer takes eight, then grants stop
    u_queue_peer.stall <= 1'b1; ngrant = 0; load(11, 12);
    repeat (60) @(posedge hclk);
    chk_cnt(ngrant, 8, 8, "fill");
    ahb(0, 8'h04, 0); chk_val(32'(rd[19:16]), 32'h0000_0008, "level");
    u_queue_peer.stall <= 1'b0;
    settle();
    // disabled: no grants
    ahb(1, 8'h00, 32'h0000_0000);
    ngrant = 0; load(4, 2);
    repeat (30) @(posedge hclk);
    chk_cnt(ngrant, 0, 0, "disabled");
    ahb(1, 8'h00, 32'h0000_0001);
    settle();
    repeat (10) @(posedge hclk);
    chk_cnt(sb.size(), 0, 0, "drained");
    summarize();
  end

  // cut a hang short
  initial begin
    repeat (30000) @(posedge hclk);
    err_total++;
    summarize();
  end
endmodule
